/* File: acs_host_model.sv */
// Host serial controller model: command bytes, 24-bit read frames and the exit pattern.
// Assumes sys_clk is the master clock; pins change just after its rising edge.
`default_nettype none
module acs_host_model #(
	parameter int HALF = 5
) (
	input wire logic sys_clk,
	input wire logic dout,
	output logic cs_n,
	output logic sclk,
	output logic din
);
	// Deselected with the link clock parked high; it stands still between frames.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end
	task automatic half_wait();
		repeat (HALF) @(posedge sys_clk);
	endtask : half_wait
	// Bits leave msb first and are taken on the rising link clock edge.
	task automatic send_byte(input logic [7:0] b);
		@(posedge sys_clk);
		cs_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			sclk <= 1'b0;
			din <= b[i];
			half_wait();
			sclk <= 1'b1;
			half_wait();
		end
		cs_n <= 1'b1;
		din <= ~b[0];
	endtask : send_byte
	// The last bit shows after the 24th rise, so a final fall is made without a 25th rise.
	task automatic read_frame(output logic [23:0] w);
		@(posedge sys_clk);
		cs_n <= 1'b0;
		din <= 1'b0;
		for (int i = 0; i < 25; i++) begin
			sclk <= 1'b0;
			half_wait();
			if (i > 0) begin
				w = {w[22:0], dout};
			end
			if (i < 24) begin
				sclk <= 1'b1;
			end
			half_wait();
		end
		cs_n <= 1'b1;
		sclk <= 1'b1;
		din <= ~w[0];
	endtask : read_frame
	// Input held high for two half periods, well past the exit time.
	task automatic exit_read();
		@(posedge sys_clk);
		cs_n <= 1'b0;
		din <= 1'b1;
		repeat (2) half_wait();
		cs_n <= 1'b1;
		din <= 1'b0;
	endtask : exit_read
endmodule : acs_host_model
`default_nettype wire

/* File: acs_pkg.sv */
// Shared constants and types for the conversion sequencer and its serial output path.
// Assumes a single 50 MHz master clock drives every register of the block.
`default_nettype none

package acs_pkg;
	// Master clock period and serial exit timing.
	localparam int CLK_PERIOD_NS = 20;
	localparam int EXIT_HIGH_NS = 100;
	localparam int EXIT_HIGH_CYC = (EXIT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Conversion phase lengths in master-clock cycles.
	localparam int SETTLE1_CYC = 43;
	localparam int SETTLE2_CYC = 42;
	localparam int SCALE_CYC = 163;
	// Serial command bytes.
	localparam logic [7:0] CMD_CONT_READ = 8'h48;
	localparam logic [7:0] CMD_EXIT_READ = 8'h80;
	// Result word layout: status byte above a 16-bit data word.
	localparam int DATA_W = 16;
	localparam int FRAME_BITS = 24;
	localparam int ST_CHAN_LSB = 5;
	localparam int ST_RDY_BIT = 4;
	localparam int ST_SIGN_BIT = 1;
	localparam int ST_OVR_BIT = 0;
	// Codes and reset values.
	localparam logic [15:0] BIPOLAR_ZERO = 16'h8000;
	localparam logic [15:0] CODE_ALL_ONES = 16'hffff;
	localparam logic [15:0] CODE_ALL_ZEROS = 16'h0000;
	localparam logic [7:0] READY_RESET = 8'h00;
	// Conversion mode commands presented with a mode write.
	typedef enum logic [1:0] {
		ACS_MODE_IDLE = 2'b00,
		ACS_MODE_SINGLE = 2'b01,
		ACS_MODE_CONT = 2'b10
	} acs_mode_e;
	// Sequencer phases.
	typedef enum logic [2:0] {
		ACS_IDLE = 3'b000,
		ACS_SETTLE1 = 3'b001,
		ACS_SAMPLE1 = 3'b010,
		ACS_SETTLE2 = 3'b011,
		ACS_SAMPLE2 = 3'b100,
		ACS_SCALE = 3'b101,
		ACS_PUSH = 3'b110
	} acs_seq_e;
endpackage : acs_pkg

`default_nettype wire

/* File: acs_sequencer.sv */
// Conversion sequencer, result buffer and continuous-read serial output.
// Assumes serial and mode inputs are synchronous to sys_clk and sclk is much slower than it.
`default_nettype none

// Small result buffer; a full buffer holds off the sequencer's result write.
module acs_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	// Pointer and fill-count update.
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
		rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; only entries below the count are ever read.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
endmodule : acs_fifo

module acs_sequencer import acs_pkg::*; #(
	parameter int N_CH = 8,
	parameter int FW_W = 7,
	parameter int SAMPLE_UNIT = 128,
	parameter int CODE_W = 19,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic mode_wr,
	input wire logic [1:0] mode_sel,
	input wire logic [2:0] mode_chan,
	input wire logic cont_read_en,
	input wire logic status_prefix_en,
	input wire logic saturation_en,
	input wire logic all_channels_ready_select,
	input wire logic two_wire_mode,
	input wire logic [N_CH-1:0] chan_enable,
	input wire logic [N_CH-1:0] chop_enable,
	input wire logic [N_CH-1:0] bipolar_enable,
	input wire logic [N_CH*FW_W-1:0] conversion_time_word,
	input wire logic signed [CODE_W-1:0] sample_code,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe_n,
	output logic rdy_n,
	output logic [N_CH-1:0] ready_flags,
	output logic mod_clk,
	output logic sampling,
	output logic chop_reverse,
	output logic [2:0] active_chan,
	output logic cont_read_active
);
	localparam int CW = 16;
	logic [1:0] rst_sync_q;
	logic rst_n;
	acs_seq_e st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [2:0] ch_q, ch_d;
	logic cont_q, cont_d, mod_q, mod_d;
	logic signed [CODE_W-1:0] s1_q, s1_d, s2_q, s2_d;
	logic [FRAME_BITS-1:0] res_q, res_d, last_q, last_d, sh_q, sh_d;
	logic [N_CH-1:0] rdyf_q, rdyf_d;
	logic rdy_n_q, rdy_n_d, samp_q, samp_d, rev_q, rev_d;
	logic crd_q, crd_d, sclk_q, dout_q, dout_d, oe_n_q, oe_n_d;
	logic [4:0] bit_q, bit_d;
	logic [7:0] cmd_q, cmd_d;
	logic [2:0] hi_q, hi_d;
	logic fifo_ready, fifo_valid, fifo_pop, push;
	logic [FRAME_BITS-1:0] fifo_data;
	logic sclk_rise, sclk_fall, frame_done;
	logic signed [CODE_W+1:0] avg, val;
	logic [15:0] code;
	logic sgn, over_range_flag;

	// Next enabled channel after the current one, wrapping; stays put if none other.
	function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [N_CH-1:0] en);
		logic [2:0] nxt;
		logic [2:0] cand;
		nxt = cur;
		for (int i = N_CH - 1; i >= 1; i--) begin
			cand = 3'(cur + 3'(i));
			if (en[cand]) begin
				nxt = cand;
			end
		end
		return nxt;
	endfunction : next_chan

	// Count loaded for a sampling period of fw units; a zero word still gives one cycle.
	function automatic logic [CW-1:0] sample_len(input logic [FW_W-1:0] fw);
		return (fw == '0) ? '0 : CW'(fw * SAMPLE_UNIT - 1);
	endfunction : sample_len

	// Reset release through two flip-flops.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Result formatting: chop average, offset, flags and clamp or wrap.
	always_comb begin
		if (chop_enable[ch_q]) begin
			avg = ((CODE_W+2)'(s1_q) - (CODE_W+2)'(s2_q)) >>> 1;
		end else begin
			avg = (CODE_W+2)'(s1_q);
		end
		val = bipolar_enable[ch_q] ? avg + (CODE_W+2)'(BIPOLAR_ZERO) : avg;
		sgn = avg < 0;
		over_range_flag = (val < 0) || (val > (CODE_W+2)'(CODE_ALL_ONES));
		if (over_range_flag && saturation_en) begin
			code = (val < 0) ? CODE_ALL_ZEROS : CODE_ALL_ONES;
		end else if (!bipolar_enable[ch_q] && sgn) begin
			code = CODE_ALL_ZEROS;
		end else begin
			code = val[15:0];
		end
	end

	// Conversion sequencer and ready flags.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		ch_d = ch_q;
		cont_d = cont_q;
		s1_d = s1_q;
		s2_d = s2_q;
		res_d = res_q;
		last_d = last_q;
		rdyf_d = rdyf_q;
		samp_d = 1'b0;
		rev_d = rev_q;
		push = 1'b0;
		mod_d = !mod_q;
		if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
		unique case (st_q)
			ACS_IDLE: ;
			ACS_SETTLE1: if (cnt_q == '0) begin
				st_d = ACS_SAMPLE1;
				cnt_d = sample_len(conversion_time_word[ch_q*FW_W +: FW_W]);
				samp_d = 1'b1;
			end
			ACS_SAMPLE1: if (cnt_q == '0) begin
				s1_d = sample_code;
				if (chop_enable[ch_q]) begin
					st_d = ACS_SETTLE2;
					cnt_d = CW'(SETTLE2_CYC - 1);
					rev_d = 1'b1;
				end else begin
					st_d = ACS_SCALE;
					cnt_d = CW'(SCALE_CYC - 1);
				end
			end else begin
				samp_d = 1'b1;
			end
			ACS_SETTLE2: if (cnt_q == '0) begin
				st_d = ACS_SAMPLE2;
				cnt_d = sample_len(conversion_time_word[ch_q*FW_W +: FW_W]);
				samp_d = 1'b1;
			end
			ACS_SAMPLE2: if (cnt_q == '0) begin
				s2_d = sample_code;
				rev_d = 1'b0;
				st_d = ACS_SCALE;
				cnt_d = CW'(SCALE_CYC - 1);
			end else begin
				samp_d = 1'b1;
			end
			ACS_SCALE: if (cnt_q == '0) begin
				res_d = {ch_q, 1'b1, 2'b00, sgn, over_range_flag, code};
				st_d = ACS_PUSH;
			end
			ACS_PUSH: begin
				// A full buffer holds the result here, stalling the next conversion.
				push = 1'b1;
				if (fifo_ready) begin
					last_d = res_q;
					rdyf_d[ch_q] = 1'b1;
					if (cont_q) begin
						ch_d = next_chan(ch_q, chan_enable);
						st_d = ACS_SETTLE1;
						cnt_d = CW'(SETTLE1_CYC - 1) + CW'(mod_q);
					end else begin
						st_d = ACS_IDLE;
					end
				end
			end
			default: st_d = ACS_IDLE;
		endcase
		// Reading clears the flag, but a flag set in the same cycle survives.
		if (frame_done && !(push && fifo_ready && ch_q == last_q[FRAME_BITS-1 -: 3])) begin
			rdyf_d[last_q[FRAME_BITS-1 -: 3]] = 1'b0;
		end
		if (mode_wr) begin
			rdyf_d = READY_RESET;
			rev_d = 1'b0;
			samp_d = 1'b0;
			ch_d = mode_chan;
			cont_d = (mode_sel == ACS_MODE_CONT);
			if (mode_sel == ACS_MODE_IDLE) begin
				st_d = ACS_IDLE;
			end else begin
				st_d = ACS_SETTLE1;
				cnt_d = CW'(SETTLE1_CYC - 1) + CW'(mod_q);
			end
		end
		// Looking at the next state too keeps the pin high from the first scaling cycle.
		if (mode_wr || st_d == ACS_SCALE || st_q == ACS_SCALE) begin
			rdy_n_d = 1'b1;
		end else if (all_channels_ready_select) begin
			rdy_n_d = ((rdyf_d & chan_enable) != chan_enable) || (chan_enable == '0);
		end else begin
			rdy_n_d = (rdyf_d == '0);
		end
	end

	// Serial edges, frame boundaries and continuous-read mode control.
	always_comb begin
		sclk_rise = sclk && !sclk_q;
		sclk_fall = !sclk && sclk_q;
		crd_d = crd_q;
		bit_d = bit_q;
		cmd_d = cmd_q;
		sh_d = sh_q;
		dout_d = dout_q;
		hi_d = hi_q;
		oe_n_d = cs_n;
		fifo_pop = 1'b0;
		frame_done = 1'b0;
		if (cs_n) begin
			bit_d = '0;
			hi_d = '0;
		end else if (crd_q) begin
			if (sclk_rise) begin
				if (bit_q == '0) begin
					// Frame begins: oldest buffered result, else the last one kept.
					fifo_pop = fifo_valid;
					sh_d = fifo_valid ? fifo_data : last_d;
				end
				bit_d = (bit_q == 5'(FRAME_BITS - 1)) ? '0 : bit_q + 1'b1;
				frame_done = (bit_q == 5'(FRAME_BITS - 1));
			end
			if (sclk_fall) begin
				dout_d = sh_q[FRAME_BITS-1];
				sh_d = {sh_q[FRAME_BITS-2:0], 1'b0};
			end
			// Serial input high between frames for long enough ends the mode.
			// The exit lands in the last high cycle, so a low input never drops the mode.
			if (din && bit_q == '0) begin
				hi_d = hi_q + 1'b1;
				if (hi_q == 3'(EXIT_HIGH_CYC - 1)) begin
					crd_d = 1'b0;
					hi_d = '0;
				end
			end else begin
				hi_d = '0;
			end
		end else if (sclk_rise) begin
			cmd_d = {cmd_q[6:0], din};
			bit_d = (bit_q == 5'd7) ? '0 : bit_q + 1'b1;
			if (bit_q == 5'd7 && {cmd_q[6:0], din} == CMD_CONT_READ && cont_read_en && !two_wire_mode) begin
				crd_d = 1'b1;
			end
		end
		if (!cont_read_en || two_wire_mode) begin
			crd_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ACS_IDLE;
			cnt_q <= '0;
			ch_q <= '0;
			cont_q <= 1'b0;
			mod_q <= 1'b0;
			s1_q <= '0;
			s2_q <= '0;
			res_q <= '0;
			last_q <= '0;
			rdyf_q <= READY_RESET;
			rdy_n_q <= 1'b1;
			samp_q <= 1'b0;
			rev_q <= 1'b0;
			crd_q <= 1'b0;
			sclk_q <= 1'b1; // Idle level of the link clock, so no false edge follows reset.
			bit_q <= '0;
			cmd_q <= '0;
			sh_q <= '0;
			dout_q <= 1'b0;
			oe_n_q <= 1'b1;
			hi_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			ch_q <= ch_d;
			cont_q <= cont_d;
			mod_q <= mod_d;
			s1_q <= s1_d;
			s2_q <= s2_d;
			res_q <= res_d;
			last_q <= last_d;
			rdyf_q <= rdyf_d;
			rdy_n_q <= rdy_n_d;
			samp_q <= samp_d;
			rev_q <= rev_d;
			crd_q <= crd_d;
			sclk_q <= sclk;
			bit_q <= bit_d;
			cmd_q <= cmd_d;
			sh_q <= sh_d;
			dout_q <= dout_d;
			oe_n_q <= oe_n_d;
			hi_q <= hi_d;
		end
	end

	acs_fifo #(
		.WIDTH(FRAME_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(res_q),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// Status prefix is always present in this path, so the enable is not consulted.
	logic unused_prefix;
	assign unused_prefix = status_prefix_en;
	assign dout = dout_q;
	assign dout_oe_n = oe_n_q;
	assign rdy_n = rdy_n_q;
	assign ready_flags = rdyf_q;
	assign mod_clk = mod_q;
	assign sampling = samp_q;
	assign chop_reverse = rev_q;
	assign active_chan = ch_q;
	assign cont_read_active = crd_q;
endmodule : acs_sequencer

`default_nettype wire

/* File: acs_sequencer_asserts.sv */
// Port checker for acs_sequencer: phase lengths, ready pin and continuous-read mode.
// Assumes binding to acs_sequencer, whose internal reset lags resetn by two edges.
`default_nettype none
module acs_sequencer_asserts import acs_pkg::*; #(
	parameter int N_CH = 8
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic mode_wr,
	input wire logic [1:0] mode_sel,
	input wire logic cont_read_en,
	input wire logic all_channels_ready_select,
	input wire logic two_wire_mode,
	input wire logic [N_CH-1:0] chan_enable,
	input wire logic din,
	input wire logic rdy_n,
	input wire logic [N_CH-1:0] ready_flags,
	input wire logic mod_clk,
	input wire logic sampling,
	input wire logic chop_reverse,
	input wire logic cont_read_active
);
	logic [2:0] rst_q, rst_d;
	logic samp_q, samp_d;
	logic [7:0] cnt_q, cnt_d;
	// Checks start one edge after the internal release, so history never holds reset values.
	always_comb begin
		rst_d = {rst_q[1:0], 1'b1};
		samp_d = sampling;
		cnt_d = cnt_q - 8'(cnt_q != 8'h00);
		if (samp_q && !sampling && !chop_reverse) begin
			cnt_d = 8'ha2;
		end
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_q <= 3'h0;
			samp_q <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			rst_q <= rst_d;
			samp_q <= samp_d;
			cnt_q <= cnt_d;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_q[2]);
	property p_settle1;
		mode_wr && mode_sel != ACS_MODE_IDLE |-> ##1 (!sampling)[*8] ##[33:39] $rose(sampling);
	endproperty
	a_settle1: assert property (p_settle1) else $error("first settle length wrong");
	property p_settle2;
		$rose(chop_reverse) |-> ##1 (!sampling)[*8] ##[31:35] $rose(sampling);
	endproperty
	a_settle2: assert property (p_settle2) else $error("second settle length wrong");
	property p_scale_rdy;
		cnt_q != 8'h00 || (samp_q && !sampling && !chop_reverse) |-> rdy_n;
	endproperty
	a_scale_rdy: assert property (p_scale_rdy) else $error("ready pin low while scaling");
	property p_flag_rdy;
		(ready_flags & ~$past(ready_flags)) != '0 && !all_channels_ready_select |-> ##[0:1] !rdy_n;
	endproperty
	a_flag_rdy: assert property (p_flag_rdy) else $error("new flag without ready pin");
	property p_all_ready;
		(all_channels_ready_select && (ready_flags & chan_enable) != chan_enable)[*2] |-> rdy_n;
	endproperty
	a_all_ready: assert property (p_all_ready) else $error("ready pin low before all channels");
	property p_mod_clk;
		!mod_clk |=> mod_clk ##1 !mod_clk;
	endproperty
	a_mod_clk: assert property (p_mod_clk) else $error("modulator clock not half rate");
	property p_two_wire;
		two_wire_mode[*3] |-> !cont_read_active;
	endproperty
	a_two_wire: assert property (p_two_wire) else $error("read mode in two-wire setup");
	property p_cr_off;
		(!cont_read_en)[*3] |-> !cont_read_active;
	endproperty
	a_cr_off: assert property (p_cr_off) else $error("read mode without enable");
	property p_cr_entry;
		$rose(cont_read_active) |-> $past(cont_read_en) && !$past(two_wire_mode);
	endproperty
	a_cr_entry: assert property (p_cr_entry) else $error("read mode entered unasked");
	property p_cr_hold;
		cont_read_active && !din && cont_read_en && !two_wire_mode |=> cont_read_active;
	endproperty
	a_cr_hold: assert property (p_cr_hold) else $error("read mode dropped with input low");
	c_cont: cover property (mode_wr && mode_sel == ACS_MODE_CONT);
	c_chop: cover property ($rose(chop_reverse));
	c_exit: cover property ($fell(cont_read_active));
endmodule : acs_sequencer_asserts
bind acs_sequencer acs_sequencer_asserts #(.N_CH(N_CH)) i_acs_sequencer_asserts (.sys_clk, .resetn, .mode_wr,
	.mode_sel, .cont_read_en, .all_channels_ready_select, .two_wire_mode, .chan_enable, .din, .rdy_n,
	.ready_flags, .mod_clk, .sampling, .chop_reverse, .cont_read_active);
`default_nettype wire

/* File: acs_sequencer_bench.sv */
// Self-checking bench for acs_sequencer with the host serial model on its link.
// Assumes SAMPLE_UNIT of 1, so a sampling period lasts as many cycles as its word.
`default_nettype none
module acs_sequencer_bench import acs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic mode_wr = 1'b0;
	logic [1:0] mode_sel = ACS_MODE_IDLE;
	logic [2:0] mode_chan = 3'h0;
	logic cont_read_en = 1'b0;
	logic status_prefix_en = 1'b0;
	logic saturation_en = 1'b0;
	logic all_channels_ready_select = 1'b0;
	logic two_wire_mode = 1'b0;
	logic [7:0] chan_enable = 8'h01;
	logic [7:0] chop_enable = 8'h00;
	logic [7:0] bipolar_enable = 8'hff;
	logic [55:0] conversion_time_word = 56'h0;
	logic signed [18:0] sample_code = 19'h0;
	logic cs_n, sclk, din, dout, dout_oe_n, rdy_n, mod_clk, sampling, chop_reverse, cont_read_active, bip, sat;
	logic [2:0] active_chan, ch;
	logic [7:0] ready_flags, cm, bm;
	logic [55:0] tw;
	logic [23:0] frame;
	int fail_count = 0;
	int checks = 0;
	int code, lat, base, s;
	int codes[8] = '{32'sh0, 32'sh7fff, 32'sh8000, 32'sh8000, -32'sh1, 32'sh0, -32'sh8001, 32'sh11170};
	acs_sequencer #(.SAMPLE_UNIT(1)) i_acs_sequencer (.sys_clk, .resetn, .mode_wr, .mode_sel, .mode_chan,
		.cont_read_en, .status_prefix_en, .saturation_en, .all_channels_ready_select, .two_wire_mode,
		.chan_enable, .chop_enable, .bipolar_enable, .conversion_time_word, .sample_code, .cs_n, .sclk, .din,
		.dout, .dout_oe_n, .rdy_n, .ready_flags, .mod_clk, .sampling, .chop_reverse, .active_chan,
		.cont_read_active);
	acs_host_model i_acs_host_model (.sys_clk, .dout, .cs_n, .sclk, .din);
	always #10 sys_clk = ~sys_clk;
	// Filter result follows the input polarity, so a chopped average returns the input code.
	always @(posedge sys_clk) begin
		sample_code <= 19'(chop_reverse ? -code : code);
	end
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Status byte above the data word; unipolar negatives read as zero with both flags.
	function automatic logic [23:0] expect_word(input logic [2:0] c, input logic b, input logic t, input int k);
		int v;
		logic over_range_flag;
		v = b ? k + 32'sh8000 : k;
		over_range_flag = v < 0 || v > 32'shffff;
		if (!b && k < 0) begin
			v = 32'sh0;
		end else if (t && over_range_flag) begin
			v = v < 0 ? 32'sh0 : 32'shffff;
		end
		return {c, 1'b1, 2'b00, k < 0, over_range_flag, v[15:0]};
	endfunction : expect_word
	task automatic write_mode(input logic [2:0] c, input logic [1:0] m);
		@(posedge sys_clk);
		mode_wr <= 1'b1;
		mode_sel <= m;
		mode_chan <= c;
		@(posedge sys_clk);
		mode_wr <= 1'b0;
	endtask : write_mode
	// Counted on falling edges so the ready pin is read settled.
	task automatic wait_rdy();
		lat = 0;
		while (rdy_n !== 1'b0 && lat < 3000) begin
			@(negedge sys_clk);
			lat++;
		end
	endtask : wait_rdy
	task automatic tally_and_finish();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// The whole run needs about 9500 cycles; this limit is well beyond it.
	initial begin
		repeat (60000) @(posedge sys_clk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(9));
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(negedge sys_clk);
		check(24'({rdy_n, ready_flags, cont_read_active, dout_oe_n}), 24'h401);
		// Buffer fills while nothing is read, then drains oldest first.
		code = int'($urandom_range(32'hffff)) - 32'sh8000;
		write_mode(3'h0, ACS_MODE_CONT);
		cont_read_en <= 1'b1;
		all_channels_ready_select <= 1'b0;
		i_acs_host_model.send_byte(CMD_CONT_READ);
		repeat (1300) @(negedge sys_clk);
		check(24'(cont_read_active), 24'h1);
		write_mode(3'h0, ACS_MODE_IDLE);
		repeat (6) begin
			i_acs_host_model.read_frame(frame);
			check(frame, expect_word(3'h0, 1'b1, 1'b0, code));
		end
		// Single conversions over corner codes, then random ones, with per-channel settings.
		for (int k = 0; k < 12; k++) begin
			ch = 3'(k);
			code = k < 8 ? codes[k] : int'($urandom_range(32'hffff)) - 32'sh8000;
			bip = k < 8 ? 1'(8'h4f >> k) : 1'($urandom);
			sat = k < 8 ? 1'(8'h48 >> k) : 1'($urandom);
			cm = 8'($urandom);
			bm = 8'($urandom);
			bm[ch] = bip;
			for (int i = 0; i < 8; i++) begin
				tw[7 * i +: 7] = 7'($urandom_range(3));
			end
			s = tw[7 * ch +: 7] == 7'h0 ? 1 : int'(tw[7 * ch +: 7]);
			base = SETTLE1_CYC + s + SCALE_CYC + 1 + (cm[ch] ? SETTLE2_CYC + s : 0);
			@(posedge sys_clk);
			chop_enable <= cm;
			bipolar_enable <= bm;
			conversion_time_word <= tw;
			saturation_en <= sat;
			status_prefix_en <= 1'($urandom);
			write_mode(ch, ACS_MODE_SINGLE);
			wait_rdy();
			check(24'(lat >= base - 1 && lat <= base + 4), 24'h1);
			check(24'({ready_flags[ch], active_chan}), 24'({1'b1, ch}));
			i_acs_host_model.read_frame(frame);
			check(frame, expect_word(ch, bip, sat, code));
			repeat (3) @(negedge sys_clk);
			check(24'({ready_flags, rdy_n}), 24'h1);
		end
		write_mode(3'h0, ACS_MODE_CONT);
		i_acs_host_model.exit_read();
		check(24'(cont_read_active), 24'h0);
		i_acs_host_model.send_byte(CMD_CONT_READ);
		check(24'(cont_read_active), 24'h1);
		cont_read_en <= 1'b0;
		repeat (3) @(negedge sys_clk);
		check(24'(cont_read_active), 24'h0);
		@(posedge sys_clk);
		cont_read_en <= 1'b1;
		two_wire_mode <= 1'b1;
		i_acs_host_model.send_byte(CMD_CONT_READ);
		check(24'(cont_read_active), 24'h0);
		two_wire_mode <= 1'b0;
		// Two channels with the all-ready select: the pin waits for both.
		write_mode(3'h0, ACS_MODE_IDLE);
		chan_enable <= 8'h03;
		all_channels_ready_select <= 1'b1;
		write_mode(3'h0, ACS_MODE_CONT);
		wait_rdy();
		check(24'(ready_flags), 24'h3);
		write_mode(3'h0, ACS_MODE_IDLE);
		repeat (2) @(negedge sys_clk);
		check(24'({ready_flags, rdy_n}), 24'h1);
		tally_and_finish();
	end
endmodule : acs_sequencer_bench
`default_nettype wire
